// ### aes_pkg.sv
package aes_pkg;
   // Control/status field positions
   localparam int CS_LAUNCH_BIT = 0;
   localparam int CS_CMD_LSB = 1;
   localparam int CS_READY_BIT = 3;
   localparam int CS_MODE_LSB = 4;
   // Reset values
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [1:0] CMD_RST = 2'h0;
   localparam logic [127:0] KEY_RST = 128'h0;
   localparam logic [127:0] IV_RST = 128'h0;
   // Transfer sizes and counts, round constants and MixColumns coefficients
   localparam logic [4:0] BLOCK_BYTES = 5'h10;
   localparam logic [4:0] PORTION_BYTES = 5'h4;
   localparam logic [1:0] LAST_PORTION = 2'h3;
   localparam logic [3:0] LAST_ROUND = 4'h9;
   localparam logic [7:0] RCON_FIRST = 8'h01;
   localparam logic [7:0] RCON_LAST = 8'h36;
   localparam logic [31:0] MIX_FWD = 32'h02030101;
   localparam logic [31:0] MIX_INV = 32'h0E0B0D09;

   typedef enum logic [2:0] {
      MODE_CBC = 3'b000,
      MODE_CFB = 3'b001,
      MODE_OFB = 3'b010,
      MODE_CTR = 3'b011,
      MODE_ECB = 3'b100,
      MODE_MAC = 3'b101
   } mode_t;

   typedef enum logic [1:0] {
      CMD_ENC = 2'b00,
      CMD_DEC = 2'b01,
      CMD_KEY = 2'b10,
      CMD_IV = 2'b11
   } cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FILL = 3'b001,
      ST_KEYGEN = 3'b010,
      ST_CRYPT = 3'b011,
      ST_MIX = 3'b100,
      ST_DRAIN = 3'b101
   } eng_state_t;

   typedef enum logic [1:0] {
      CORE_IDLE = 2'b00,
      CORE_EXPAND = 2'b01,
      CORE_ROUND = 2'b10
   } core_state_t;

   typedef struct packed {
      logic [2:0] mode;
      cmd_t cmd;
      logic launch;
   } cs_write_t;

   typedef struct packed {
      logic go;
      logic decrypt;
      logic [127:0] block;
   } core_req_t;
endpackage : aes_pkg

// ### aes_round_core.sv
`timescale 1ns/1ps
module aes_round_core (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input aes_pkg::core_req_t req_i,
   input wire logic abort_i,
   input wire logic [127:0] key_i,
   output logic done_o,
   output logic [127:0] result_o
);
   import aes_pkg::*;

   function automatic logic [7:0] xt(input logic [7:0] a);
      return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
   endfunction : xt

   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] t;
      p = 8'h00;
      t = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) p = p ^ t;
         t = xt(t);
      end
      return p;
   endfunction : gmul

   // Field inverse as a^254
   function automatic logic [7:0] ginv(input logic [7:0] a);
      logic [7:0] p;
      logic [7:0] r;
      p = a;
      r = 8'h01;
      for (int i = 1; i < 8; i++) begin
         p = gmul(p, p);
         r = gmul(r, p);
      end
      return r;
   endfunction : ginv

   function automatic logic [7:0] sbox(input logic [7:0] a);
      logic [7:0] v;
      v = ginv(a);
      return v ^ {v[6:0], v[7]} ^ {v[5:0], v[7:6]} ^ {v[4:0], v[7:5]} ^ {v[3:0], v[7:4]} ^ 8'h63;
   endfunction : sbox

   function automatic logic [7:0] isbox(input logic [7:0] a);
      return ginv({a[6:0], a[7]} ^ {a[4:0], a[7:5]} ^ {a[1:0], a[7:2]} ^ 8'h05);
   endfunction : isbox

   function automatic logic [31:0] mixcol(input logic [31:0] c, input logic [31:0] m);
      logic [31:0] o;
      o = 32'h0;
      for (int r = 0; r < 4; r++) begin
         for (int j = 0; j < 4; j++) begin
            o[31-8*r -: 8] = o[31-8*r -: 8] ^ gmul(c[31-8*j -: 8], m[31-8*((j-r+4)%4) -: 8]);
         end
      end
      return o;
   endfunction : mixcol

   function automatic logic [127:0] fwd_round(input logic [127:0] s, input logic [127:0] k,
                                              input logic last);
      logic [127:0] t;
      t = 128'h0;
      for (int i = 0; i < 16; i++) begin
         t[127-8*i -: 8] = sbox(s[127-8*((i%4)+4*(((i/4)+(i%4))%4)) -: 8]);
      end
      for (int c = 0; c < 4; c++) begin
         if (!last) t[127-32*c -: 32] = mixcol(t[127-32*c -: 32], MIX_FWD);
      end
      return t ^ k;
   endfunction : fwd_round

   function automatic logic [127:0] inv_round(input logic [127:0] s, input logic [127:0] k,
                                              input logic last);
      logic [127:0] t;
      t = 128'h0;
      for (int i = 0; i < 16; i++) begin
         t[127-8*i -: 8] = isbox(s[127-8*((i%4)+4*(((i/4)-(i%4)+4)%4)) -: 8]);
      end
      t = t ^ k;
      for (int c = 0; c < 4; c++) begin
         if (!last) t[127-32*c -: 32] = mixcol(t[127-32*c -: 32], MIX_INV);
      end
      return t;
   endfunction : inv_round

   function automatic logic [31:0] subrot(input logic [31:0] w, input logic [7:0] rc);
      return {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
   endfunction : subrot

   function automatic logic [127:0] key_fwd(input logic [127:0] k, input logic [7:0] rc);
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] w2;
      w0 = k[127:96] ^ subrot(k[31:0], rc);
      w1 = k[95:64] ^ w0;
      w2 = k[63:32] ^ w1;
      return {w0, w1, w2, k[31:0] ^ w2};
   endfunction : key_fwd

   function automatic logic [127:0] key_inv(input logic [127:0] k, input logic [7:0] rc);
      logic [31:0] w3;
      w3 = k[31:0] ^ k[63:32];
      return {k[127:96] ^ subrot(w3, rc), k[95:64] ^ k[127:96], k[63:32] ^ k[95:64], w3};
   endfunction : key_inv

   core_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [127:0] data_q, data_d;
   logic [127:0] rk_q, rk_d;
   logic [7:0] rc_q, rc_d;
   logic dec_q, dec_d;
   logic done_q, done_d;

   always_comb begin
      logic [127:0] nk;
      nk = 128'h0;
      st_d = st_q;
      cnt_d = cnt_q;
      data_d = data_q;
      rk_d = rk_q;
      rc_d = rc_q;
      dec_d = dec_q;
      done_d = 1'b0;
      unique case (st_q)
         CORE_IDLE: begin
            if (req_i.go) begin
               dec_d = req_i.decrypt;
               cnt_d = 4'h0;
               rk_d = key_i;
               rc_d = RCON_FIRST;
               data_d = req_i.decrypt ? req_i.block : req_i.block ^ key_i;
               st_d = req_i.decrypt ? CORE_EXPAND : CORE_ROUND;
            end
         end
         CORE_EXPAND: begin
            nk = key_fwd(rk_q, rc_q);
            rk_d = nk;
            rc_d = xt(rc_q);
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == LAST_ROUND) begin
               data_d = data_q ^ nk;
               rc_d = RCON_LAST;
               cnt_d = 4'h0;
               st_d = CORE_ROUND;
            end
         end
         CORE_ROUND: begin
            if (dec_q) begin
               nk = key_inv(rk_q, rc_q);
               data_d = inv_round(data_q, nk, cnt_q == LAST_ROUND);
               rc_d = (rc_q == 8'h1B) ? 8'h80 : {1'b0, rc_q[7:1]};
            end else begin
               nk = key_fwd(rk_q, rc_q);
               data_d = fwd_round(data_q, nk, cnt_q == LAST_ROUND);
               rc_d = xt(rc_q);
            end
            rk_d = nk;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == LAST_ROUND) begin
               done_d = 1'b1;
               st_d = CORE_IDLE;
            end
         end
         default: st_d = CORE_IDLE;
      endcase
      if (abort_i) begin
         st_d = CORE_IDLE;
         done_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= CORE_IDLE;
         cnt_q <= 4'h0;
         data_q <= 128'h0;
         rk_q <= 128'h0;
         rc_q <= 8'h00;
         dec_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         data_q <= data_d;
         rk_q <= rk_d;
         rc_q <= rc_d;
         dec_q <= dec_d;
         done_q <= done_d;
      end
   end

   assign done_o = done_q;
   assign result_o = data_q;
endmodule : aes_round_core

// ### aes_block_cipher_engine.sv
`timescale 1ns/1ps
// Function
// - Key or IV load aborts running block
// - Stream modes move four 32-bit portions
// - Result read out before next block
// - Key persists until next key load
// - Reset clears key and IV
// - Start raises input DMA trigger
// - Interrupt on each finished block
// - CBC-MAC chains silently, CBC yields MAC
// - Counter mode increments 32-bit counter
// - Command field selects operation
// - Start bit self-clears
// - Ready low while busy, resets high
// - Fetch and drain triggers
module aes_block_cipher_engine (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic cs_wr_i,
   input aes_pkg::cs_write_t cs_wdata_i,
   output logic [7:0] cipher_control_status_o,
   input wire logic in_wr_i,
   input wire logic [7:0] cipher_input_byte_i,
   input wire logic out_rd_i,
   output logic [7:0] cipher_output_byte_o,
   output logic input_fetch_trigger_o,
   output logic output_drain_trigger_o,
   output logic block_done_irq_o
);
   import aes_pkg::*;

   eng_state_t st_q, st_d;
   logic [2:0] mode_q, mode_d;
   cmd_t cmd_q, cmd_d;
   logic launch_q, launch_d;
   logic [127:0] key_q, key_d, iv_q, iv_d, buf_q, buf_d, res_q, res_d, ks_q, ks_d;
   logic [4:0] cnt_q, cnt_d;
   logic [1:0] part_q, part_d;
   logic fetch_q, fetch_d, drain_q, drain_d, irq_q, irq_d, go_q, go_d;
   logic ready, streaming, is_load, accept, abort, core_done;
   logic [4:0] chunk;
   logic [127:0] core_res;
   core_req_t core_req;

   assign ready = (st_q == ST_IDLE);
   assign streaming = !cmd_q[1] && (mode_q inside {MODE_CFB, MODE_OFB, MODE_CTR});
   assign chunk = streaming ? PORTION_BYTES : BLOCK_BYTES;
   assign is_load = cs_wdata_i.cmd[1];
   // Loads always win; block commands only when idle
   assign accept = cs_wr_i && cs_wdata_i.launch && (is_load || ready);
   assign abort = accept && is_load;

   assign core_req.go = go_q;
   assign core_req.decrypt = (cmd_q == CMD_DEC) && !streaming && (mode_q != MODE_MAC);
   assign core_req.block = streaming ? iv_q
      : (((cmd_q == CMD_ENC && mode_q == MODE_CBC) || mode_q == MODE_MAC) ? buf_q ^ iv_q : buf_q);

   aes_round_core u_core (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .req_i(core_req),
      .abort_i(abort),
      .key_i(key_q),
      .done_o(core_done),
      .result_o(core_res)
   );

   always_comb begin
      logic [31:0] w;
      logic [31:0] k;
      logic [31:0] o;
      w = buf_q[31:0];
      k = ks_q[127-32*part_q -: 32];
      o = w ^ k;
      st_d = st_q;
      mode_d = mode_q;
      cmd_d = cmd_q;
      launch_d = 1'b0;
      key_d = key_q;
      iv_d = iv_q;
      buf_d = buf_q;
      res_d = res_q;
      ks_d = ks_q;
      cnt_d = cnt_q;
      part_d = part_q;
      fetch_d = 1'b0;
      drain_d = 1'b0;
      irq_d = 1'b0;
      go_d = 1'b0;
      if (cs_wr_i && (ready || is_load)) begin
         mode_d = cs_wdata_i.mode;
         cmd_d = cs_wdata_i.cmd;
      end
      if (accept) begin
         launch_d = 1'b1;
         fetch_d = 1'b1;
         cnt_d = 5'h0;
         part_d = 2'h0;
         st_d = ST_FILL;
      end else begin
         unique case (st_q)
            ST_IDLE: ;
            ST_FILL: begin
               if (in_wr_i) begin
                  buf_d = {buf_q[119:0], cipher_input_byte_i};
                  cnt_d = cnt_q + 5'h1;
                  if (cnt_q == chunk - 5'h1) begin
                     unique case (cmd_q)
                        CMD_KEY: begin
                           key_d = buf_d;
                           st_d = ST_IDLE;
                        end
                        CMD_IV: begin
                           iv_d = buf_d;
                           st_d = ST_IDLE;
                        end
                        default: begin
                           go_d = !streaming || part_q == 2'h0;
                           st_d = streaming ? (go_d ? ST_KEYGEN : ST_MIX) : ST_CRYPT;
                        end
                     endcase
                  end
               end
            end
            ST_KEYGEN: begin
               if (core_done) begin
                  ks_d = core_res;
                  st_d = ST_MIX;
               end
            end
            ST_MIX: begin
               res_d = {o, 96'h0};
               if (mode_q == MODE_CFB) iv_d[127-32*part_q -: 32] = (cmd_q == CMD_DEC) ? w : o;
               if (mode_q == MODE_OFB) iv_d[127-32*part_q -: 32] = k;
               if (mode_q == MODE_CTR && part_q == LAST_PORTION) begin
                  iv_d[31:0] = iv_q[31:0] + 32'h1;
               end
               drain_d = 1'b1;
               cnt_d = 5'h0;
               st_d = ST_DRAIN;
            end
            ST_CRYPT: begin
               if (core_done) begin
                  res_d = core_res;
                  if (mode_q == MODE_CBC && cmd_q == CMD_DEC) begin
                     res_d = core_res ^ iv_q;
                     iv_d = buf_q;
                  end else if (mode_q == MODE_CBC || mode_q == MODE_MAC) begin
                     iv_d = core_res;
                  end
                  cnt_d = 5'h0;
                  if (mode_q == MODE_MAC) begin
                     irq_d = 1'b1;
                     st_d = ST_IDLE;
                  end else begin
                     drain_d = 1'b1;
                     st_d = ST_DRAIN;
                  end
               end
            end
            ST_DRAIN: begin
               if (out_rd_i) begin
                  res_d = {res_q[119:0], 8'h00};
                  cnt_d = cnt_q + 5'h1;
                  if (cnt_q == chunk - 5'h1) begin
                     cnt_d = 5'h0;
                     if (streaming && part_q != LAST_PORTION) begin
                        part_d = part_q + 2'h1;
                        fetch_d = 1'b1;
                        st_d = ST_FILL;
                     end else begin
                        irq_d = 1'b1;
                        st_d = ST_IDLE;
                     end
                  end
               end
            end
            default: st_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= ST_IDLE;
         mode_q <= MODE_RST;
         cmd_q <= cmd_t'(CMD_RST);
         launch_q <= 1'b0;
         key_q <= KEY_RST;
         iv_q <= IV_RST;
         buf_q <= 128'h0;
         res_q <= 128'h0;
         ks_q <= 128'h0;
         cnt_q <= 5'h0;
         part_q <= 2'h0;
         fetch_q <= 1'b0;
         drain_q <= 1'b0;
         irq_q <= 1'b0;
         go_q <= 1'b0;
      end else begin
         st_q <= st_d;
         mode_q <= mode_d;
         cmd_q <= cmd_d;
         launch_q <= launch_d;
         key_q <= key_d;
         iv_q <= iv_d;
         buf_q <= buf_d;
         res_q <= res_d;
         ks_q <= ks_d;
         cnt_q <= cnt_d;
         part_q <= part_d;
         fetch_q <= fetch_d;
         drain_q <= drain_d;
         irq_q <= irq_d;
         go_q <= go_d;
      end
   end

   always_comb begin
      cipher_control_status_o = 8'h00;
      cipher_control_status_o[CS_LAUNCH_BIT] = launch_q;
      cipher_control_status_o[CS_CMD_LSB +: 2] = cmd_q;
      cipher_control_status_o[CS_READY_BIT] = ready;
      cipher_control_status_o[CS_MODE_LSB +: 3] = mode_q;
   end
   assign cipher_output_byte_o = res_q[127:120];
   assign input_fetch_trigger_o = fetch_q;
   assign output_drain_trigger_o = drain_q;
   assign block_done_irq_o = irq_q;

   chk_load_aborts: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      abort |=> st_q == ST_FILL && !core_done) else $error("load did not abort");
   chk_launch_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      launch_q |=> !launch_q) else $error("start bit stuck");
   chk_launch_fetch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      accept |=> input_fetch_trigger_o && launch_q) else $error("no fetch trigger on start");
   chk_busy_status: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      accept |=> !cipher_control_status_o[CS_READY_BIT]) else $error("ready high while busy");
   chk_drain_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      output_drain_trigger_o |-> !ready [*4]) else $error("ready before result read");
   chk_irq_ready: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      block_done_irq_o |-> ready && !$past(ready)) else $error("irq not at block end");
   chk_key_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !(st_q == ST_FILL && cmd_q == CMD_KEY) |=> $stable(key_q)) else $error("key changed");
   chk_ctr_step: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      st_q == ST_MIX && mode_q == MODE_CTR && part_q == LAST_PORTION && !accept
      |=> iv_q[31:0] == $past(iv_q[31:0]) + 32'h1 && iv_q[127:32] == $past(iv_q[127:32]))
      else $error("counter step wrong");
   chk_mac_silent: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      st_q == ST_CRYPT && core_done && mode_q == MODE_MAC && !accept
      |=> block_done_irq_o && !output_drain_trigger_o) else $error("MAC mode drained");
endmodule : aes_block_cipher_engine

// ### cpu_dma_model.sv
`timescale 1ns/1ps
module cpu_dma_model (
   input wire logic clk_i,
   input wire logic [7:0] status_i,
   input wire logic [7:0] out_byte_i,
   input wire logic fetch_i,
   input wire logic drain_i,
   input wire logic irq_i,
   output logic cs_wr_o,
   output aes_pkg::cs_write_t cs_wdata_o,
   output logic in_wr_o,
   output logic [7:0] in_byte_o,
   output logic out_rd_o
);
   import aes_pkg::*;

   initial begin
      cs_wr_o = 1'h0;
      cs_wdata_o = '0;
      in_wr_o = 1'h0;
      in_byte_o = 8'h00;
      out_rd_o = 1'h0;
   end

   function automatic logic pick(input int sel);
      case (sel)
         0: return fetch_i;
         1: return drain_i;
         2: return irq_i;
         default: return status_i[CS_READY_BIT];
      endcase
   endfunction : pick

   // Bounded wait, current cycle looked at first
   task automatic wait_ev(input int sel, inout logic ok);
      int n;
      n = 0;
      while (pick(sel) !== 1'h1 && n < 400) begin
         @(negedge clk_i);
         n++;
      end
      if (pick(sel) !== 1'h1) ok = 1'h0;
   endtask : wait_ev

   // Direct control write, data then moved byte-wise
   task automatic ctrl(input logic [2:0] m, input cmd_t c);
      @(negedge clk_i);
      cs_wdata_o = '{mode: m, cmd: c, launch: 1'h1};
      cs_wr_o = 1'h1;
      @(negedge clk_i);
      cs_wr_o = 1'h0;
      cs_wdata_o = cs_write_t'(~cs_wdata_o);
   endtask : ctrl

   // Bytes first to first+n-1 of d; a whole block or one 4-byte portion
   task automatic push(input logic [127:0] d, input int first, input int n);
      for (int i = first; i < first + n; i++) begin
         @(negedge clk_i);
         in_wr_o = 1'h1;
         in_byte_o = d[127 - 8 * i -: 8];
      end
      @(negedge clk_i);
      in_wr_o = 1'h0;
      in_byte_o = ~in_byte_o;
   endtask : push

   task automatic pull(input int n, inout logic [127:0] res);
      for (int i = 0; i < n; i++) begin
         @(negedge clk_i);
         res = {res[119:0], out_byte_i};
         out_rd_o = 1'h1;
      end
      @(negedge clk_i);
      out_rd_o = 1'h0;
   endtask : pull

   // Load command first, then the key or IV bytes
   task automatic load(input logic [2:0] m, input cmd_t c, input logic [127:0] v,
         output logic ok);
      ok = 1'h1;
      ctrl(m, c);
      wait_ev(0, ok);
      push(v, 0, 16);
      wait_ev(3, ok);
   endtask : load

   // One launch per block; separate fill and drain streams
   task automatic block(input logic [2:0] m, input cmd_t c, input logic [127:0] d,
         output logic [127:0] res, output logic ok);
      logic strm;
      strm = (m == MODE_CFB || m == MODE_OFB || m == MODE_CTR);
      ok = 1'h1;
      res = '0;
      ctrl(m, c);
      for (int p = 0; p < (strm ? 4 : 1); p++) begin
         wait_ev(0, ok);
         push(d, strm ? p * 4 : 0, strm ? 4 : 16);
         if (m != MODE_MAC) begin
            wait_ev(1, ok);
            pull(strm ? 4 : 16, res);
         end
      end
      wait_ev(2, ok);
      if (status_i[CS_READY_BIT] !== 1'h1) ok = 1'h0;
   endtask : block
endmodule : cpu_dma_model

// ### tb.sv
`timescale 1ns/1ps
module tb;
   import aes_pkg::*;
   localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
   localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
   localparam logic [127:0] CT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
   localparam logic [127:0] PT2 = 128'h69D5C2EB2E2E624750541D3BBC692BA5;
   localparam logic [127:0] ZCT = 128'h66E94BD4EF8A2C3B884CFA59CA342B2E;
   localparam logic [127:0] ZERO = 128'h0;

   typedef struct packed {
      logic [1:0] ld;
      logic [2:0] mode;
      cmd_t cmd;
      logic [127:0] kv;
      logic [127:0] din;
      logic [127:0] exp;
      logic chk;
   } row_t;

   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic cs_wr;
   cs_write_t cs_wdata;
   logic [7:0] status;
   logic in_wr;
   logic [7:0] in_byte;
   logic out_rd;
   logic [7:0] out_byte;
   logic fetch;
   logic drain;
   logic irq;
   logic ok;
   logic [127:0] got;
   int n_fail = 0;
   int comparisons = 0;
   int n_irq = 0;
   int cycles = 0;
   int base;
   row_t rows [12];

   always #4 clk = ~clk;

   aes_block_cipher_engine dut (
      .clk_i(clk), .reset_n_i(reset_n), .cs_wr_i(cs_wr), .cs_wdata_i(cs_wdata),
      .cipher_control_status_o(status), .in_wr_i(in_wr), .cipher_input_byte_i(in_byte),
      .out_rd_i(out_rd), .cipher_output_byte_o(out_byte), .input_fetch_trigger_o(fetch),
      .output_drain_trigger_o(drain), .block_done_irq_o(irq)
   );

   cpu_dma_model model (
      .clk_i(clk), .status_i(status), .out_byte_i(out_byte), .fetch_i(fetch),
      .drain_i(drain), .irq_i(irq), .cs_wr_o(cs_wr), .cs_wdata_o(cs_wdata),
      .in_wr_o(in_wr), .in_byte_o(in_byte), .out_rd_o(out_rd)
   );

   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude();
      if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude

   always @(negedge clk) begin
      if (irq === 1'h1) n_irq++;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         conclude();
      end
   end

   initial begin
      rows = '{
         '{2'h0, MODE_ECB, CMD_ENC, ZERO, ZERO, ZCT, 1'h1},
         '{2'h1, MODE_ECB, CMD_ENC, KEY, PT, CT, 1'h1},
         '{2'h0, MODE_ECB, CMD_DEC, ZERO, CT, PT, 1'h1},
         '{2'h2, MODE_CBC, CMD_ENC, ZERO, PT, CT, 1'h1},
         '{2'h0, MODE_CBC, CMD_ENC, ZERO, PT2, CT, 1'h1},
         '{2'h2, MODE_MAC, CMD_ENC, ZERO, PT, ZERO, 1'h0},
         '{2'h0, MODE_CBC, CMD_ENC, ZERO, PT2, CT, 1'h1},
         '{2'h0, MODE_CBC, CMD_DEC, ZERO, CT, PT2, 1'h1},
         '{2'h2, MODE_OFB, CMD_ENC, PT, ZERO, CT, 1'h1},
         '{2'h2, MODE_CFB, CMD_ENC, PT, ZERO, CT, 1'h1},
         '{2'h2, MODE_CTR, CMD_ENC, PT, ZERO, CT, 1'h1},
         '{2'h2, MODE_CFB, CMD_DEC, PT, ZERO, CT, 1'h1}};
      repeat (12) @(negedge clk);
      check(status, 8'h08);
      check({out_byte, fetch, drain, irq}, 11'h000);
      reset_n = 1'h1;
      foreach (rows[i]) begin
         if (rows[i].ld != 2'h0) begin
            model.load(rows[i].mode, rows[i].ld == 2'h1 ? CMD_KEY : CMD_IV, rows[i].kv, ok);
            check(ok, 1'h1);
         end
         model.block(rows[i].mode, rows[i].cmd, rows[i].din, got, ok);
         check(ok, 1'h1);
         if (rows[i].chk) check(got, rows[i].exp);
      end
      // Self-clearing launch, busy refusal, then abort by key load
      model.ctrl(MODE_ECB, CMD_ENC);
      check({status[CS_LAUNCH_BIT], status[CS_READY_BIT], fetch}, 3'h5);
      @(negedge clk);
      check(status[CS_LAUNCH_BIT], 1'h0);
      model.push(PT, 0, 16);
      model.ctrl(MODE_OFB, CMD_ENC);
      check(status[CS_MODE_LSB +: 3], MODE_ECB);
      check(status[CS_READY_BIT], 1'h0);
      base = n_irq;
      model.load(MODE_ECB, CMD_KEY, KEY, ok);
      check(ok, 1'h1);
      check(n_irq, base);
      model.block(MODE_ECB, CMD_ENC, PT, got, ok);
      check(got, CT);
      // Reset in mid-block clears the key
      model.ctrl(MODE_ECB, CMD_ENC);
      reset_n = 1'h0;
      @(negedge clk);
      check(status, 8'h08);
      reset_n = 1'h1;
      model.block(MODE_ECB, CMD_ENC, ZERO, got, ok);
      check(got, ZCT);
      @(negedge clk);
      check(n_irq, 14);
      conclude();
   end
endmodule : tb
